// file: rtl/vfdu_pkg.sv
/*
 * Package for the VLIW fetch and dispatch front end: packet geometry,
 * unit slots, register file shape, instruction field positions and
 * addressing constants.
 * Assumes one core clock and no software-visible registers.
 */
package vfdu_pkg;
    // Fetch packet geometry
    localparam int FETCH_BITS = 256;
    localparam int WORD_BITS = 32;
    localparam int WORDS_PER_FETCH = FETCH_BITS / WORD_BITS;
    // Units: per side logic, shift/arith, multiply, data-address
    localparam int UNITS_PER_SIDE = 4;
    localparam int NUM_UNITS = 2 * UNITS_PER_SIDE;
    localparam logic [1:0] UNIT_LOGIC = 2'h0;
    localparam logic [1:0] UNIT_SHIFT_ARITH = 2'h1;
    localparam logic [1:0] UNIT_MULTIPLY = 2'h2;
    localparam logic [1:0] UNIT_DATA_ADDR = 2'h3;
    // Register files
    localparam int REGS_PER_SIDE = 16;
    localparam int REG_IDX_BITS = 4;
    // Instruction field positions
    localparam int CHAIN_BIT = 0;
    localparam int SIDE_BIT = 1;
    localparam int UNIT_LSB = 2;
    localparam int UNIT_MSB = 3;
    localparam int XPATH_BIT = 4;
    localparam int OP_LSB = 5;
    localparam int OP_MSB = 7;
    localparam int SRC2_LSB = 8;
    localparam int SRC1_LSB = 13;
    localparam int DST_LSB = 18;
    localparam int SIZE_LSB = 23;
    localparam int SIZE_MSB = 24;
    localparam int CIRC_BIT = 25;
    localparam int LONG_OFS_BIT = 26;
    localparam int ZBIT = 27;
    localparam int COND_LSB = 28;
    localparam int COND_MSB = 31;
    // Condition encoding: zero means always execute
    localparam logic [3:0] COND_ALWAYS = 4'h0;
    // Offset widths for data-address units
    localparam int SHORT_OFS_BITS = 5;
    localparam int LONG_OFS_BITS = 15;
    // Access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // Circular buffer length (bytes, power of two)
    localparam logic [31:0] CIRC_MASK = 32'h0000_00FF;
    // Opcode values
    localparam logic [2:0] OP_ADD = 3'h0;
    localparam logic [2:0] OP_SUB = 3'h1;
    localparam logic [2:0] OP_AND = 3'h2;
    localparam logic [2:0] OP_OR = 3'h3;
    localparam logic [2:0] OP_XOR = 3'h4;
    localparam logic [2:0] OP_SHL = 3'h5;
    localparam logic [2:0] OP_LOAD = 3'h6;
    localparam logic [2:0] OP_STORE = 3'h7;
    // Reset fetch address
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
endpackage

// file: rtl/vfdu_core.sv
/*
 * Fetch and dispatch front end with the two-sided execution datapath.
 * Fetches 256-bit packets, splits them on the chain bit, issues one
 * execute packet per clock to eight units over two register files.
 * Assumes program memory answers a request in a later cycle with
 * pmem_valid_i, and data memory completes each access in one cycle.
 */
module vfdu_core
    import vfdu_pkg::*;
#(
    parameter int ADDR_BITS = 32
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Program memory
    output logic pmem_req_o,
    output logic [ADDR_BITS-1:0] pmem_addr_o,
    input wire logic pmem_valid_i,
    input wire logic [FETCH_BITS-1:0] pmem_data_i,
    // Data memory, one port per data-address unit
    output logic [1:0] dmem_en_o,
    output logic [1:0] dmem_we_o,
    output logic [2*ADDR_BITS-1:0] dmem_addr_o,
    output logic [7:0] dmem_be_o,
    output logic [63:0] dmem_wdata_o,
    input wire logic [63:0] dmem_rdata_i,
    // Issue status
    output logic issue_valid_o,
    output logic [NUM_UNITS-1:0] unit_busy_o,
    output logic [NUM_UNITS-1:0] unit_annul_o,
    output logic issue_error_o
);
    // Fetch sequencer: IDLE lets one cycle pass after the last group of
    // a packet, WAIT holds the program memory request until the packet
    // arrives, and ISSUE hands out one execute packet per clock.
    // The idle cycle costs some throughput but keeps the next request
    // strictly after the final dispatch, so a packet is never fetched
    // early and the issue logic never sees a half-replaced packet.
    // There is no branch or stall input: the front end runs straight.
    typedef enum logic [1:0] {VFDU_IDLE, VFDU_WAIT, VFDU_ISSUE} vfdu_state_e;

    vfdu_state_e state; // Fetch state
    logic [FETCH_BITS-1:0] packet; // Current fetch packet
    logic [WORDS_PER_FETCH-1:0] pending; // Words not yet issued
    logic [ADDR_BITS-1:0] pc; // Next fetch address
    // Both files reset to zero; reads are combinational and writes land
    // at the edge that ends the issue cycle.
    logic [WORD_BITS-1:0] rf [2][REGS_PER_SIDE]; // Side A and B files
    logic [WORDS_PER_FETCH-1:0] grp; // Words in this execute packet
    logic [WORDS_PER_FETCH-1:0] next_pending; // Pending after this group
    logic grp_last; // Group empties the packet
    logic [WORD_BITS-1:0] slot_ins [NUM_UNITS]; // Word routed per unit
    logic [NUM_UNITS-1:0] slot_use; // Unit receives a word
    logic [NUM_UNITS-1:0] slot_go; // Condition true
    logic slot_clash; // Two words name one unit
    logic [1:0] xbus_reads; // Cross reads per direction
    logic [WORD_BITS-1:0] slot_res [NUM_UNITS]; // Unit results
    logic [WORD_BITS-1:0] slot_src1 [NUM_UNITS]; // First operand per unit
    logic [WORD_BITS-1:0] slot_src2 [NUM_UNITS]; // Second operand per unit

    // Group is a run of pending words up to the first clear chain bit
    // A set chain bit on the last word is ignored: the group simply ends
    // at the packet edge, since a group never straddles two packets.
    // The scan is a ripple over eight words, short enough for one cycle.
    always_comb begin
        logic open;
        open = 1'b1;
        grp = '0;
        for (int w = 0; w < WORDS_PER_FETCH; w++) begin
            if (pending[w] && open) begin
                grp[w] = 1'b1;
                // Chain bit zero closes the group after this word
                if (!packet[w*WORD_BITS+CHAIN_BIT]) begin
                    open = 1'b0;
                end
                // Chain bit one keeps the group open
            end
        end
        next_pending = pending & ~grp;
        grp_last = (next_pending == '0);
    end

    // Route group words onto unit slots; extra words past a clash drop
    // A clash is flagged rather than stalled: the first word keeps the
    // unit and later ones are discarded, so the issue rate stays one
    // group per clock even for malformed code.
    always_comb begin
        logic [WORD_BITS-1:0] ins;
        logic [2:0] u;
        ins = '0;
        u = '0;
        slot_use = '0;
        slot_clash = 1'b0;
        for (int s = 0; s < NUM_UNITS; s++) begin
            slot_ins[s] = '0;
        end
        for (int w = 0; w < WORDS_PER_FETCH; w++) begin
            ins = packet[w*WORD_BITS +: WORD_BITS];
            u = {ins[SIDE_BIT], ins[UNIT_MSB:UNIT_LSB]};
            if (grp[w] && state == VFDU_ISSUE) begin
                if (slot_use[u]) begin
                    slot_clash = 1'b1;
                end else begin
                    slot_use[u] = 1'b1;
                    slot_ins[u] = ins;
                end
            end
        end
    end

    // Condition test; the condition field picks register cond[3:1] of
    // the side named by cond[0], so only the low eight registers of a
    // file can hold a condition.  A zero field always executes, and an
    // idle slot never goes, which keeps all of its writes switched off.
    always_comb begin
        logic [3:0] c;
        logic [WORD_BITS-1:0] cr;
        c = '0;
        cr = '0;
        for (int s = 0; s < NUM_UNITS; s++) begin
            c = slot_ins[s][COND_MSB:COND_LSB];
            cr = rf[c[0]][{1'b0, c[3:1]}];
            if (c == COND_ALWAYS) begin
                slot_go[s] = slot_use[s];
            end else begin
                // Z bit inverts the sense of the test
                slot_go[s] = slot_use[s]
                    && ((cr != '0) ^ slot_ins[s][ZBIT]);
            end
        end
    end

    // Operand read: same side direct, other side over the cross bus
    // The cross bus is granted in slot order, so a second claimant on
    // the same side quietly reads its own file instead.
    always_comb begin
        logic side;
        side = 1'b0;
        xbus_reads = '0;
        for (int s = 0; s < NUM_UNITS; s++) begin
            side = s[2];
            slot_src2[s] = rf[side][slot_ins[s][SRC2_LSB +: REG_IDX_BITS]];
            slot_src1[s] = rf[side][slot_ins[s][SRC1_LSB +: REG_IDX_BITS]];
            // One cross read per direction: the first claimant wins
            if (slot_use[s] && slot_ins[s][XPATH_BIT]
                    && !xbus_reads[side]) begin
                xbus_reads[side] = 1'b1;
                slot_src2[s] =
                    rf[!side][slot_ins[s][SRC2_LSB +: REG_IDX_BITS]];
            end
        end
    end

    // Execution results; multiplies only on multiply slots
    // Multiply slots ignore the opcode and form a 16 by 16 product, so
    // no other slot needs a multiplier; loads and stores fall to the
    // default add, whose result is written back only on logic and shift slots.
    always_comb begin
        logic [2:0] op;
        op = '0;
        for (int s = 0; s < NUM_UNITS; s++) begin
            op = slot_ins[s][OP_MSB:OP_LSB];
            if (s[1:0] == UNIT_MULTIPLY) begin
                slot_res[s] = slot_src1[s][15:0]
                    * slot_src2[s][15:0];
            end else begin
                case (op)
                    OP_ADD: slot_res[s] = slot_src1[s] + slot_src2[s];
                    OP_SUB: slot_res[s] = slot_src1[s] - slot_src2[s];
                    OP_AND: slot_res[s] = slot_src1[s] & slot_src2[s];
                    OP_OR: slot_res[s] = slot_src1[s] | slot_src2[s];
                    OP_XOR: slot_res[s] = slot_src1[s] ^ slot_src2[s];
                    OP_SHL: slot_res[s] = slot_src1[s]
                        << slot_src2[s][4:0];
                    default: slot_res[s] = slot_src1[s] + slot_src2[s];
                endcase
            end
        end
    end

    // Data-address units: address gen, size lanes, memory strobes
    // Offsets are scaled by the access size before the add; circular
    // mode keeps the high bits of the base, so a circular buffer must
    // be aligned to its own length.
    for (genvar d = 0; d < 2; d++) begin : g_daddr
        localparam int S = d * UNITS_PER_SIDE + 3;
        logic [2:0] op;
        logic [WORD_BITS-1:0] ofs;
        logic [WORD_BITS-1:0] lin;
        logic [WORD_BITS-1:0] ea;
        logic [1:0] sz;
        logic [3:0] be;
        logic [WORD_BITS-1:0] st;
        logic [WORD_BITS-1:0] sreg; // Register being stored
        assign op = slot_ins[S][OP_MSB:OP_LSB];
        assign sz = slot_ins[S][SIZE_MSB:SIZE_LSB];
        // Offset field is 5 or 15 bits, scaled by access size
        assign ofs = slot_ins[S][LONG_OFS_BIT]
            ? {17'h0, slot_ins[S][SRC2_LSB +: LONG_OFS_BITS]}
            : {27'h0, slot_ins[S][SRC2_LSB +: SHORT_OFS_BITS]};
        assign lin = slot_src1[S] + (ofs << sz);
        // Circular mode wraps inside the aligned buffer
        assign ea = slot_ins[S][CIRC_BIT]
            ? ((slot_src1[S] & ~CIRC_MASK) | (lin & CIRC_MASK))
            : lin;
        always_comb begin
            case (sz)
                SIZE_BYTE: be = 4'h1 << ea[1:0];
                SIZE_HALF: be = ea[1] ? 4'hC : 4'h3;
                default: be = 4'hF;
            endcase
        end
        // Stored register is named by the destination field; the cross
        // bit takes it from the other file, as it does for loads
        assign sreg = rf[1'(d) ^ slot_ins[S][XPATH_BIT]]
            [slot_ins[S][DST_LSB +: REG_IDX_BITS]];
        // Narrow stores take the low bits of the register, copied onto
        // every lane so that the byte enables alone pick the bytes
        always_comb begin
            case (sz)
                SIZE_BYTE: st = {4{sreg[7:0]}};
                SIZE_HALF: st = {2{sreg[15:0]}};
                default: st = sreg;
            endcase
        end
        // Annulled loads and stores never reach memory
        assign dmem_en_o[d] = slot_go[S]
            && (op == OP_LOAD || op == OP_STORE);
        assign dmem_we_o[d] = slot_go[S] && op == OP_STORE;
        assign dmem_addr_o[d*ADDR_BITS +: ADDR_BITS] = ea;
        assign dmem_be_o[d*4 +: 4] = be;
        assign dmem_wdata_o[d*32 +: 32] = st;
    end

    // Fetch sequencing: request only after the last group issues
    // Program memory data is ignored outside WAIT, so a stray valid
    // pulse while issuing cannot overwrite the packet in flight.
    // A packet therefore costs at least three clocks: the request,
    // one issue cycle and the idle cycle.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state <= VFDU_IDLE;
            pc <= RESET_PC;
            pending <= '0;
            packet <= '0;
        end else begin
            case (state)
                VFDU_IDLE: begin
                    state <= VFDU_WAIT;
                end
                VFDU_WAIT: begin
                    if (pmem_valid_i) begin
                        packet <= pmem_data_i;
                        pending <= '1;
                        pc <= pc + ADDR_BITS'(FETCH_BITS / 8);
                        state <= VFDU_ISSUE;
                    end
                end
                VFDU_ISSUE: begin
                    pending <= next_pending;
                    if (grp_last) begin
                        state <= VFDU_IDLE;
                    end
                end
                default: state <= VFDU_IDLE;
            endcase
        end
    end

    // Register write-back; side ports serve all units, loads may land
    // in either file, chosen by the cross bit of the data unit.
    // Later slots win a same-register collision.  Load data is taken
    // at the end of the issue cycle, so data memory must answer in the
    // same cycle; a slower memory would need a stall not built here.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            for (int f = 0; f < 2; f++) begin
                for (int r = 0; r < REGS_PER_SIDE; r++) begin
                    rf[f][r] <= '0;
                end
            end
        end else begin
            for (int s = 0; s < NUM_UNITS; s++) begin
                logic side;
                logic [2:0] op;
                logic [WORD_BITS-1:0] ld;
                side = s[2];
                op = slot_ins[s][OP_MSB:OP_LSB];
                ld = dmem_rdata_i[side*32 +: 32];
                if (slot_go[s]) begin
                    if (s[1:0] == UNIT_DATA_ADDR) begin
                        if (op == OP_LOAD) begin
                            // Destination file chosen by cross bit
                            rf[side ^ slot_ins[s][XPATH_BIT]]
                              [slot_ins[s][DST_LSB +: REG_IDX_BITS]]
                                <= ld;
                        end else if (op != OP_STORE) begin
                            rf[side][slot_ins[s][DST_LSB +: REG_IDX_BITS]]
                                <= slot_res[s];
                        end
                    end else begin
                        rf[side][slot_ins[s][DST_LSB +: REG_IDX_BITS]]
                            <= slot_res[s];
                    end
                end
            end
        end
    end

    // Outputs toward program memory and observers
    // Handshake and status outputs decode registered state and the
    // held packet only, so they settle early in every cycle.
    assign pmem_req_o = (state == VFDU_WAIT);
    assign pmem_addr_o = pc;
    assign issue_valid_o = (state == VFDU_ISSUE);
    assign unit_busy_o = slot_use;
    assign unit_annul_o = slot_use & ~slot_go;
    assign issue_error_o = slot_clash;
endmodule

// file: sim/vfdu_core_checker.sv
/* Port-level assertions for vfdu_core.
   Assumes the bind below and one clock with a synchronous reset. */
module vfdu_core_checker
    import vfdu_pkg::*;
#(
    parameter int ADDR_BITS = 32
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Program memory
    input wire logic pmem_req_o,
    input wire logic [ADDR_BITS-1:0] pmem_addr_o,
    input wire logic pmem_valid_i,
    // Data memory and issue status
    input wire logic [1:0] dmem_en_o,
    input wire logic [1:0] dmem_we_o,
    input wire logic issue_valid_o,
    input wire logic [NUM_UNITS-1:0] unit_busy_o,
    input wire logic [NUM_UNITS-1:0] unit_annul_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ADDR_BITS-1:0] last_addr; // Address of last packet taken
    logic seen_take; // No step check before the first packet
    logic [3:0] grp_cnt; // Groups issued from the current packet
    // Track the taken packet and count its groups
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            seen_take <= 1'b0;
            grp_cnt <= 4'h0;
        end else if (pmem_req_o && pmem_valid_i) begin
            seen_take <= 1'b1;
            grp_cnt <= 4'h0;
        end else if (issue_valid_o) begin
            grp_cnt <= grp_cnt + 4'h1;
        end
    end
    // Address kept apart so a reset leaves it alone
    always_ff @(posedge core_clk_i) begin
        if (pmem_req_o && pmem_valid_i) begin
            last_addr <= pmem_addr_o;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    AST_NO_FETCH_IN_ISSUE: assert property (
        issue_valid_o |-> !pmem_req_o) else $error("fetch while issuing");
    AST_REQ_HOLDS: assert property (
        pmem_req_o && !pmem_valid_i |=> pmem_req_o && $stable(pmem_addr_o))
        else $error("request dropped early");
    AST_ADDR_STEP: assert property (
        $rose(pmem_req_o) && seen_take |->
        pmem_addr_o == last_addr + ADDR_BITS'(32))
        else $error("fetch address did not step by 32");
    AST_ISSUE_AFTER_TAKE: assert property (
        pmem_req_o && pmem_valid_i |=> issue_valid_o)
        else $error("no issue after packet taken");
    AST_GROUPS_BOUND: assert property (
        grp_cnt <= 4'h8) else $error("more than eight groups");
    AST_IDLE_THEN_FETCH: assert property (
        $fell(issue_valid_o) |-> !pmem_req_o ##1 pmem_req_o)
        else $error("refetch timing wrong");
    AST_ISSUE_NONEMPTY: assert property (
        issue_valid_o |-> unit_busy_o != '0) else $error("empty issue");
    AST_IDLE_UNITS: assert property (
        !issue_valid_o |-> unit_busy_o == '0 && dmem_en_o == 2'h0)
        else $error("unit active without issue");
    AST_ANNUL_IN_BUSY: assert property (
        (unit_annul_o & ~unit_busy_o) == '0) else $error("stray annul");
    AST_DMEM_SIDE_A: assert property (
        dmem_en_o[0] |-> unit_busy_o[3] && !unit_annul_o[3])
        else $error("side A access without live data unit");
    AST_DMEM_SIDE_B: assert property (
        dmem_en_o[1] |-> unit_busy_o[7] && !unit_annul_o[7])
        else $error("side B access without live data unit");
    AST_STORE_STROBE: assert property (
        (dmem_we_o & ~dmem_en_o) == 2'h0) else $error("store without enable");
endmodule
bind vfdu_core vfdu_core_checker #(.ADDR_BITS(ADDR_BITS)) vfdu_core_checker_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .pmem_req_o(pmem_req_o),
    .pmem_addr_o(pmem_addr_o), .pmem_valid_i(pmem_valid_i),
    .dmem_en_o(dmem_en_o), .dmem_we_o(dmem_we_o),
    .issue_valid_o(issue_valid_o), .unit_busy_o(unit_busy_o),
    .unit_annul_o(unit_annul_o));

// file: sim/vfdu_mem_model.sv
/* Program and data memory model for the fetch and dispatch bench.
   Assumes the bench supplies the packet and the answer latency. */
module vfdu_mem_model
    import vfdu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Program memory
    input wire logic req_i,
    output logic valid_o,
    output logic [FETCH_BITS-1:0] data_o,
    // Data memory
    input wire logic [1:0] en_i,
    input wire logic [63:0] addr_i,
    output logic [63:0] rdata_o,
    // Bench control
    input wire logic [FETCH_BITS-1:0] pkt_i,
    input wire logic [3:0] lat_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt; // Cycles the request has waited
    logic flip; // Toggles so idle data never looks stable
    initial begin
        valid_o = 1'b0;
        data_o = '0;
        flip = 1'b0;
    end
    // Answer after lat_i cycles; data is garbage outside the pulse
    always @(posedge core_clk_i) begin
        flip <= rstn_i ? ~flip : 1'b0;
        if (rstn_i && req_i && !valid_o && wait_cnt == lat_i) begin
            valid_o <= 1'b1;
            data_o <= pkt_i;
        end else begin
            valid_o <= 1'b0;
            data_o <= ~pkt_i ^ {FETCH_BITS{flip}};
        end
        wait_cnt <= (rstn_i && req_i && !valid_o) ? wait_cnt + 4'h1 : 4'h0;
    end
    // Reads answer in the same cycle; with no enable set both lanes keep changing
    assign rdata_o = (en_i != 2'h0) ? ~addr_i : {64{flip}};
endmodule

// file: sim/vfdu_core_tb.sv
/* Self-checking bench for vfdu_core.
   Assumes vfdu_mem_model as program and data memory. */
module vfdu_core_tb
    import vfdu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, rstn_i, pmem_req_o, pmem_valid_i;
    logic [31:0] pmem_addr_o;
    logic [FETCH_BITS-1:0] pmem_data_i, pkt;
    logic [1:0] dmem_en_o, dmem_we_o;
    logic [63:0] dmem_addr_o, dmem_wdata_o, dmem_rdata_i;
    logic [7:0] dmem_be_o, unit_busy_o, unit_annul_o;
    logic issue_valid_o, issue_error_o;
    logic [3:0] lat_r; // Memory answer latency
    logic [31:0] wd [8]; // Words of the next packet
    logic [92:0] rec_q [$]; // One record per issued group
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    vfdu_core vfdu_core_i (.core_clk_i, .rstn_i, .pmem_req_o, .pmem_addr_o,
        .pmem_valid_i, .pmem_data_i, .dmem_en_o, .dmem_we_o, .dmem_addr_o,
        .dmem_be_o, .dmem_wdata_o, .dmem_rdata_i, .issue_valid_o,
        .unit_busy_o, .unit_annul_o, .issue_error_o);
    vfdu_mem_model vfdu_mem_model_i (.core_clk_i, .rstn_i,
        .req_i(pmem_req_o), .valid_o(pmem_valid_i), .data_o(pmem_data_i),
        .en_i(dmem_en_o), .addr_i(dmem_addr_o), .rdata_o(dmem_rdata_i),
        .pkt_i(pkt), .lat_i(lat_r));
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // Record outputs of every issue cycle at the falling edge, where
    // the combinational issue outputs have settled
    always @(negedge core_clk_i) begin
        cyc++;
        if (issue_valid_o === 1'b1) begin
            rec_q.push_back({dmem_wdata_o[63:32], issue_error_o, dmem_we_o,
                dmem_en_o, dmem_be_o, unit_annul_o, unit_busy_o,
                dmem_addr_o[63:32]});
        end
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk_vec(string name, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_cnt(string name, int exp, int got);
        total_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    function automatic logic [31:0] word(logic s, logic [1:0] u,
        logic [2:0] op, logic ch);
        return {24'h0, op, 1'b0, u, s, ch};
    endfunction
    // Load one packet and collect the groups issued from it
    task automatic run_packet(input logic [3:0] lat);
        int i;
        rec_q.delete();
        @(negedge core_clk_i);
        lat_r = lat;
        for (i = 0; i < 8; i++) begin
            pkt[32*i +: 32] = wd[i];
        end
        for (i = 0; i < 80; i++) begin
            @(negedge core_clk_i);
            if (rec_q.size() > 0 && issue_valid_o === 1'b0) break;
        end
    endtask
    task automatic fill_add();
        int i;
        for (i = 0; i < 8; i++) begin
            wd[i] = word(1'b0, UNIT_LOGIC, OP_ADD, 1'b0);
        end
    endtask
    // Chain bits all zero: eight single-word groups in word order
    task automatic test_split();
        int i;
        for (i = 0; i < 8; i++) begin
            wd[i] = word(1'(i / 4), 2'(i % 4), OP_ADD, 1'b0);
        end
        run_packet(4'h0);
        chk_cnt("group count", 8, rec_q.size());
        for (i = 0; i < rec_q.size(); i++) begin
            chk_vec("busy", 32'h1 << i, rec_q[i][39:32]);
        end
    endtask
    // All chained, last chain bit set too: one full-width group
    task automatic test_chain();
        int i;
        for (i = 0; i < 8; i++) begin
            wd[i] = word(1'(i / 4), 2'(i % 4), OP_ADD, 1'b1);
        end
        run_packet(4'h4);
        chk_cnt("group count", 1, rec_q.size());
        chk_vec("busy", 32'hFF, rec_q[0][39:32]);
        chk_vec("error", 32'h0, rec_q[0][60]);
    endtask
    // Two words for one unit in a group are flagged
    task automatic test_dup();
        fill_add();
        wd[0][CHAIN_BIT] = 1'b1;
        run_packet(4'h1);
        chk_cnt("group count", 7, rec_q.size());
        chk_vec("error", 32'h1, rec_q[0][60]);
        chk_vec("busy", 32'h1, rec_q[0][39:32]);
        chk_vec("error", 32'h0, rec_q[1][60]);
    endtask
    // Condition on a zero register: false annuls, inverted runs
    task automatic test_annul();
        fill_add();
        wd[0] = word(1'b0, UNIT_DATA_ADDR, OP_LOAD, 1'b1) | 32'h2000_0000;
        wd[1] = word(1'b1, UNIT_DATA_ADDR, OP_LOAD, 1'b0) | 32'h2800_0000;
        run_packet(4'h2);
        chk_vec("busy", 32'h88, rec_q[0][39:32]);
        chk_vec("annul", 32'h08, rec_q[0][47:40]);
        chk_vec("enable", 32'h2, rec_q[0][57:56]);
        chk_vec("write", 32'h0, rec_q[0][59:58]);
    endtask
    // Side B stores of each size at offset one, of a fresh sum
    task automatic test_sizes();
        logic [3:0] be_exp [3];
        logic [31:0] wd_exp [3];
        int s;
        be_exp = '{4'h2, 4'hC, 4'hF};
        // Side B register 0 holds all ones from the load of test_annul,
        // so the add leaves all ones minus one in register 2
        wd_exp = '{32'hFEFE_FEFE, 32'hFFFE_FFFE, 32'hFFFF_FFFE};
        for (s = 0; s < 3; s++) begin
            fill_add();
            wd[0] = word(1'b1, UNIT_LOGIC, OP_ADD, 1'b0) | (2 << DST_LSB);
            wd[1] = word(1'b1, UNIT_DATA_ADDR, OP_STORE, 1'b0)
                | (s << SIZE_LSB) | (1 << SRC2_LSB) | (5 << SRC1_LSB)
                | (2 << DST_LSB);
            run_packet(4'h1);
            chk_vec("address", 32'h1 << s, rec_q[1][31:0]);
            chk_vec("lanes", be_exp[s], rec_q[1][55:52]);
            chk_vec("strobes", 32'hA, rec_q[1][59:56]);
            chk_vec("store data", wd_exp[s], rec_q[1][92:61]);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Reset, then each scenario in turn
    initial begin
        rstn_i = 1'b0;
        pkt = '0;
        lat_r = 4'h1;
        repeat (5) @(negedge core_clk_i);
        rstn_i = 1'b1;
        test_split();
        test_chain();
        test_dup();
        test_annul();
        test_sizes();
        finish_test();
    end
endmodule
